// ---- src/gipc_top.v ----
// Design decisions made here: the strobed register port and the register offsets.
`include "gipc_consts.vh"

module gipc_top #(
  parameter INH_DELAY_CYC = `GIPC_INH_DELAY_CYC
) (
  input  wire                      clk,
  input  wire                      rst_b,
  input  wire [`GIPC_ADDR_W-1:0]   addr,
  input  wire [`GIPC_DATA_W-1:0]   wrData,
  input  wire                      wrStb,
  input  wire                      rdStb,
  output wire [`GIPC_DATA_W-1:0]   rdData,
  input  wire [`GIPC_NUM_INTS-1:0] intPin_b,
  input  wire                      vinGood,
  input  wire [`GIPC_NUM_GROUPS-1:0] okIn,
  output wire [`GIPC_NUM_GROUPS-1:0] okOut,
  output wire [`GIPC_NUM_GROUPS-1:0] okOe_b,
  output wire [`GIPC_NUM_GROUPS-1:0] progReq,
  input  wire [`GIPC_NUM_GROUPS-1:0] progDone,
  output wire [`GIPC_NUM_GROUPS-1:0] marginUp,
  output wire [`GIPC_NUM_GROUPS-1:0] marginDown
);

  localparam NG = `GIPC_NUM_GROUPS;
  localparam NI = `GIPC_NUM_INTS;
  // Synchronised bundle: interrupt inputs, then OK lines, then the supply flag.
  localparam SW = NI + NG + 1;

  // Configuration and state registers.
  reg [NG-1:0]              autoOnReg;
  reg [NI-1:0]              intFuncReg;
  reg [`GIPC_MAP_W-1:0]     intMapReg;
  reg [NG-1:0]              groupOnReg;
  reg [NG-1:0]              groupOnNext;
  reg [NG-1:0]              progBusyReg;
  reg [NG-1:0]              progBusyNext;
  reg [NG-1:0]              progStatusReg;
  reg [NG-1:0]              progStatusNext;
  reg [NG-1:0]              progReqReg;
  reg [NG-1:0]              progReqNext;
  reg [NG-1:0]              marginUpReg;
  reg [NG-1:0]              marginDownReg;
  reg [NG-1:0]              okOeBReg;
  reg [NG-1:0]              okOutReg;
  reg [NI-1:0]              intActReg;
  reg [NI-1:0]              intActPrevReg;
  reg                       vinPrevReg;
  reg [`GIPC_DATA_W-1:0]    rdDataReg;
  reg [`GIPC_CNT_W-1:0]     filtCnt [0:NI-1];

  wire [SW-1:0]             syncBus;
  wire [NI-1:0]             intSync_b;
  wire [NG-1:0]             okSync;
  wire                      vinSync;
  wire [NG-1:0]             inhibitHit;
  wire                      wrCmd;
  wire                      wrMargin;
  wire [NG-1:0]             cmdOn;
  wire [NG-1:0]             cmdOff;
  wire [1:0]                marginGrp;
  wire [1:0]                marginDir;
  wire                      vinRise;
  wire                      wrCfg;
  wire                      wrFunc;
  wire                      wrMap;
  wire [NG-1:0]             trigRise;
  wire [NG-1:0]             trigFall;
  wire [NG-1:0]             okPullReq;

  integer i;
  integer g;

  // Collects the groups that any active inhibit-role input is assigned to.
  function [NG-1:0] inhibitGroups;
    input [NI-1:0]          func;
    input [NI-1:0]          act;
    input [`GIPC_MAP_W-1:0] map;
    integer k;
    begin
      inhibitGroups = `GIPC_RESET_NIBBLE;
      for (k = 0; k < NI; k = k + 1) begin
        if (!func[k] && act[k]) begin
          inhibitGroups = inhibitGroups | map[k*NG +: NG];
        end
      end
    end
  endfunction

  // True when a write strobe addresses the given register index.
  function wrHit;
    input                    stb;
    input [`GIPC_ADDR_W-1:0] a;
    input [`GIPC_ADDR_W-1:0] idx;
    begin
      wrHit = stb && (a == idx);
    end
  endfunction

  gipc_sync #(
    .WIDTH     (SW),
    .RESET_VAL (`GIPC_SYNC_RESET)
  ) uSync (
    .clk     (clk),
    .rst_b   (rst_b),
    .asyncIn ({vinGood, okIn, intPin_b}),
    .syncOut (syncBus)
  );

  assign intSync_b = syncBus[NI-1:0];
  assign okSync    = syncBus[NI+NG-1:NI];
  assign vinSync   = syncBus[NI+NG];

  assign wrCmd     = wrHit(wrStb, addr, `GIPC_REG_GROUP_CMD);
  assign wrMargin  = wrHit(wrStb, addr, `GIPC_REG_MARGIN_CMD);
  assign wrCfg     = wrHit(wrStb, addr, `GIPC_REG_GROUP_CFG);
  assign wrFunc    = wrHit(wrStb, addr, `GIPC_REG_INT_FUNC);
  assign wrMap     = wrHit(wrStb, addr, `GIPC_REG_INT_MAP);
  assign cmdOn     = wrCmd ? wrData[`GIPC_CMD_ON_LSB +: NG] : `GIPC_RESET_NIBBLE;
  assign cmdOff    = wrCmd ? wrData[`GIPC_CMD_OFF_LSB +: NG] : `GIPC_RESET_NIBBLE;
  assign marginGrp = wrData[`GIPC_MARGIN_GRP_LSB +: 2];
  assign marginDir = wrData[`GIPC_MARGIN_DIR_LSB +: 2];
  // Auto turn-on fires once per rising edge of the supply flag.
  assign vinRise   = vinSync && !vinPrevReg;

  // Reprogram-trigger edges of the qualified interrupt levels.
  assign trigRise  = intFuncReg & intActReg & ~intActPrevReg;
  assign trigFall  = intFuncReg & ~intActReg & intActPrevReg;

  assign inhibitHit = inhibitGroups(intFuncReg, intActReg, intMapReg);

  // Per-group power, programming and command handling.
  always @* begin
    groupOnNext    = groupOnReg;
    progBusyNext   = progBusyReg;
    progStatusNext = progStatusReg;
    progReqNext    = `GIPC_RESET_NIBBLE;
    // release clears status; a completion in the same cycle still sets
    if (|trigFall) begin
      progStatusNext = `GIPC_RESET_NIBBLE;
    end
    if (vinRise) begin
      groupOnNext = groupOnNext | autoOnReg;
    end
    for (g = 0; g < NG; g = g + 1) begin
      if (cmdOn[g]) begin
        groupOnNext[g] = 1'b1;
      end
      if (trigRise[g]) begin
        progReqNext[g]  = 1'b1;
        progBusyNext[g] = 1'b1;
      end
      // auto-on after programming; inhibit does not block it
      if (progBusyReg[g] && progDone[g]) begin
        progBusyNext[g]   = 1'b0;
        progStatusNext[g] = 1'b1;
        if (autoOnReg[g]) begin
          groupOnNext[g] = 1'b1;
        end
      end
      // commanded off; off wins over on in one write
      if (cmdOff[g]) begin
        groupOnNext[g] = 1'b0;
      end
      if (trigFall[g]) begin
        groupOnNext[g]  = 1'b0;
        progBusyNext[g] = 1'b0;
      end
    end
  end

  // Interrupt input qualification.
  // A low shorter than the qualify delay never reaches the groups.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < NI; i = i + 1) begin
        filtCnt[i] <= {`GIPC_CNT_W{1'b0}};
      end
      intActReg     <= `GIPC_RESET_NIBBLE;
      intActPrevReg <= `GIPC_RESET_NIBBLE;
    end else begin
      intActPrevReg <= intActReg;
      for (i = 0; i < NI; i = i + 1) begin
        if (intSync_b[i]) begin
          filtCnt[i]   <= {`GIPC_CNT_W{1'b0}};
          intActReg[i] <= 1'b0;
        end else if (filtCnt[i] == INH_DELAY_CYC[`GIPC_CNT_W-1:0]) begin
          intActReg[i] <= 1'b1;
        end else begin
          filtCnt[i] <= filtCnt[i] + {{(`GIPC_CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // Software registers and group state.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      autoOnReg     <= `GIPC_RESET_NIBBLE;
      intFuncReg    <= `GIPC_RESET_NIBBLE;
      intMapReg     <= `GIPC_RESET_WORD;
      groupOnReg    <= `GIPC_RESET_NIBBLE;
      progBusyReg   <= `GIPC_RESET_NIBBLE;
      progStatusReg <= `GIPC_RESET_NIBBLE;
      progReqReg    <= `GIPC_RESET_NIBBLE;
      marginUpReg   <= `GIPC_RESET_NIBBLE;
      marginDownReg <= `GIPC_RESET_NIBBLE;
      vinPrevReg    <= 1'b0;
    end else begin
      vinPrevReg    <= vinSync;
      groupOnReg    <= groupOnNext;
      progBusyReg   <= progBusyNext;
      progStatusReg <= progStatusNext;
      progReqReg    <= progReqNext;
      if (wrCfg) begin
        autoOnReg <= wrData[NG-1:0];
      end
      // role and group set; four inputs; one role bit each
      if (wrFunc) begin
        intFuncReg <= wrData[NI-1:0];
      end
      if (wrMap) begin
        intMapReg <= wrData[`GIPC_MAP_W-1:0];
      end
      if (wrMargin) begin
        marginUpReg[marginGrp]   <= (marginDir == `GIPC_DIR_UP);
        marginDownReg[marginGrp] <= (marginDir == `GIPC_DIR_DOWN);
      end
    end
  end

  // any source holds the line low
  assign okPullReq = ~groupOnReg | inhibitHit;

  // Open-drain OK drivers; the enable is low while the line is pulled.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      okOeBReg <= `GIPC_RESET_NIBBLE;
      okOutReg <= `GIPC_RESET_NIBBLE;
    end else begin
      okOutReg <= `GIPC_RESET_NIBBLE;
      // inhibit pulls; any source holds line low
      okOeBReg <= ~okPullReq;
    end
  end

  // Read port, data valid for the single cycle after the strobe.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdDataReg <= `GIPC_RESET_WORD;
    end else if (rdStb) begin
      case (addr)
        `GIPC_REG_GROUP_CFG:  rdDataReg <= {12'h000, autoOnReg};
        `GIPC_REG_GROUP_CMD:  rdDataReg <= {12'h000, groupOnReg};
        `GIPC_REG_MARGIN_CMD: rdDataReg <= {8'h00, marginDownReg, marginUpReg};
        `GIPC_REG_INT_FUNC:   rdDataReg <= {12'h000, intFuncReg};
        `GIPC_REG_INT_MAP:    rdDataReg <= intMapReg;
        `GIPC_REG_STATUS: begin
          rdDataReg <= `GIPC_RESET_WORD;
          rdDataReg[`GIPC_STAT_ON_LSB +: NG]   <= groupOnReg;
          rdDataReg[`GIPC_STAT_INT_LSB +: NI]  <= intActReg;
          rdDataReg[`GIPC_STAT_OK_LSB +: NG]   <= okSync;
          rdDataReg[`GIPC_STAT_PROG_LSB +: NG] <= progStatusReg;
        end
        default:              rdDataReg <= `GIPC_RESET_WORD;
      endcase
    end else begin
      rdDataReg <= `GIPC_RESET_WORD;
    end
  end

  assign rdData     = rdDataReg;
  assign okOut      = okOutReg;
  assign okOe_b     = okOeBReg;
  assign progReq    = progReqReg;
  assign marginUp   = marginUpReg;
  assign marginDown = marginDownReg;

endmodule

// ---- src/gipc_consts.vh ----
`ifndef GIPC_CONSTS_VH
`define GIPC_CONSTS_VH

`define GIPC_NUM_GROUPS      4
`define GIPC_NUM_INTS        4
`define GIPC_ADDR_W          4
`define GIPC_DATA_W          16
`define GIPC_MAP_W           16

`define GIPC_REG_GROUP_CFG   4'h0
`define GIPC_REG_GROUP_CMD   4'h1
`define GIPC_REG_MARGIN_CMD  4'h2
`define GIPC_REG_INT_FUNC    4'h3
`define GIPC_REG_INT_MAP     4'h4
`define GIPC_REG_STATUS      4'h5

`define GIPC_CMD_ON_LSB      0
`define GIPC_CMD_OFF_LSB     4
`define GIPC_MARGIN_GRP_LSB  0
`define GIPC_MARGIN_DIR_LSB  2
`define GIPC_DIR_NOMINAL     2'h0
`define GIPC_DIR_UP          2'h1
`define GIPC_DIR_DOWN        2'h2

`define GIPC_STAT_ON_LSB     0
`define GIPC_STAT_INT_LSB    4
`define GIPC_STAT_OK_LSB     8
`define GIPC_STAT_PROG_LSB   12

`define GIPC_RESET_NIBBLE    4'h0
`define GIPC_RESET_WORD      16'h0000
`define GIPC_SYNC_RESET      9'h0FF

`define GIPC_CLK_PERIOD_NS   8
`define GIPC_INH_DELAY_NS    10000
`define GIPC_INH_DELAY_CYC   ((`GIPC_INH_DELAY_NS + `GIPC_CLK_PERIOD_NS - 1) / `GIPC_CLK_PERIOD_NS)
`define GIPC_CNT_W           11

`endif

// ---- src/gipc_sync.v ----
// Two-flop synchroniser for a bundle of independent asynchronous levels.
module gipc_sync #(
  parameter WIDTH     = 9,
  parameter RESET_VAL = 9'h0FF
) (
  input  wire             clk,
  input  wire             rst_b,
  input  wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1Reg;
  reg [WIDTH-1:0] stage2Reg;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1Reg <= RESET_VAL;
      stage2Reg <= RESET_VAL;
    end else begin
      stage1Reg <= asyncIn;
      stage2Reg <= stage1Reg;
    end
  end

  assign syncOut = stage2Reg;

endmodule

// ---- test/gipc_conv_model.sv ----
module gipc_conv_model #(
  parameter LAT = 5
) (
  input  logic       clk,
  input  logic       rst_b,
  input  logic [3:0] okOe_b,
  input  logic [3:0] progReq,
  output logic [3:0] okIn,
  output logic [3:0] progDone,
  output logic [3:0] convOn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt [4];
  assign okIn = okOe_b;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      progDone <= 4'h0;
      convOn   <= 4'h0;
      for (int g = 0; g < 4; g++) cnt[g] <= 4'h0;
    end else begin
      convOn <= okIn;
      for (int g = 0; g < 4; g++) begin
        progDone[g] <= (cnt[g] == 4'h1);
        if (progReq[g]) cnt[g] <= 4'(LAT);
        else if (cnt[g] != 4'h0) cnt[g] <= cnt[g] - 4'h1;
      end
    end
  end
endmodule

// ---- test/gipc_top_sva.sv ----
`include "gipc_consts.vh"
module gipc_top_sva #(
  parameter INH_DELAY_CYC = `GIPC_INH_DELAY_CYC
) (
  input logic        clk,
  input logic        rst_b,
  input logic [3:0]  addr,
  input logic [15:0] wrData,
  input logic        wrStb,
  input logic        rdStb,
  input logic [15:0] rdData,
  input logic [3:0]  intPin_b,
  input logic        vinGood,
  input logic [3:0]  okIn,
  input logic [3:0]  okOut,
  input logic [3:0]  okOe_b,
  input logic [3:0]  progReq,
  input logic [3:0]  progDone,
  input logic [3:0]  marginUp,
  input logic [3:0]  marginDown
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]  funcReg;
  logic [15:0] mapReg;
  logic [15:0] lowCnt;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      funcReg <= 4'h0;
      mapReg  <= 16'h0000;
      lowCnt  <= 16'h0000;
    end else begin
      if (wrStb && addr == `GIPC_REG_INT_FUNC) funcReg <= wrData[3:0];
      if (wrStb && addr == `GIPC_REG_INT_MAP) mapReg <= wrData;
      lowCnt <= intPin_b[0] ? 16'h0000 : lowCnt + {15'h0000, lowCnt != 16'hFFFF};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  margin_excl_a: assert property ((marginUp & marginDown) == 4'h0)
    else $error("margin up and down together");
  rd_idle_a: assert property (!$past(rdStb) |-> rdData == 16'h0000)
    else $error("read data outside read cycle");
  ok_drive_a: assert property (okOut == 4'h0)
    else $error("OK line driven high");
  prog_pulse_a: assert property (progReq != 4'h0 |=> (progReq & $past(progReq)) == 4'h0)
    else $error("program request longer than one cycle");
  prog_fixed_a: assert property ((progReq & ~$past(funcReg)) == 4'h0)
    else $error("program request for non-trigger group");
  margin_up_a: assert property (wrStb && addr == `GIPC_REG_MARGIN_CMD &&
    wrData[3:2] == `GIPC_DIR_UP |=> marginUp[$past(wrData[1:0])]) else $error("margin up lost");
  off_cmd_a: assert property (wrStb && addr == `GIPC_REG_GROUP_CMD && wrData[4]
    |-> ##[1:4] !okOe_b[0]) else $error("turn-off command ignored");
  inh_pull_a: assert property (lowCnt == INH_DELAY_CYC + 4 && !funcReg[0]
    |-> ##[0:4] (okOe_b & mapReg[3:0]) == 4'h0) else $error("inhibit did not pull OK");
  reprog_rel_a: assert property ($rose(intPin_b[0]) && funcReg[0] &&
    $past(lowCnt) > INH_DELAY_CYC + 4 |-> ##[1:6] !okOe_b[0]) else $error("release kept OK");
  cover property (progReq[0]);
  cover property ($rose(marginDown[3]));
  cover property (lowCnt == INH_DELAY_CYC + 4 && !funcReg[0]);
endmodule

bind gipc_top gipc_top_sva #(.INH_DELAY_CYC(INH_DELAY_CYC)) chk (.clk(clk), .rst_b(rst_b),
  .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
  .intPin_b(intPin_b), .vinGood(vinGood), .okIn(okIn), .okOut(okOut), .okOe_b(okOe_b),
  .progReq(progReq), .progDone(progDone), .marginUp(marginUp), .marginDown(marginDown));

// ---- test/gipc_top_tb_top.sv ----
`include "gipc_consts.vh"
module gipc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam INH = 8;
  logic        clk;
  logic        rst_b;
  logic [3:0]  addr;
  logic [15:0] wrData;
  logic        wrStb;
  logic        rdStb;
  logic [15:0] rdData;
  logic [3:0]  intPin_b;
  logic        vinGood;
  logic [3:0]  okIn;
  logic [3:0]  okOut;
  logic [3:0]  okOe_b;
  logic [3:0]  progReq;
  logic [3:0]  progDone;
  logic [3:0]  convOn;
  logic [3:0]  marginUp;
  logic [3:0]  marginDown;
  int          nErrors;
  int          totalChecks;
  gipc_top #(.INH_DELAY_CYC(INH)) uut (.clk(clk), .rst_b(rst_b), .addr(addr),
    .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .intPin_b(intPin_b),
    .vinGood(vinGood), .okIn(okIn), .okOut(okOut), .okOe_b(okOe_b), .progReq(progReq),
    .progDone(progDone), .marginUp(marginUp), .marginDown(marginDown));
  gipc_conv_model #(.LAT(5)) far (.clk(clk), .rst_b(rst_b), .okOe_b(okOe_b),
    .progReq(progReq), .okIn(okIn), .progDone(progDone), .convOn(convOn));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task completeRun;
    $display("checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    totalChecks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      nErrors++;
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
  endtask
  task rdc(input string n, input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1;
    chk(n, e, rdData);
  endtask
  task pin(input int i, input logic v);
    @(posedge clk);
    intPin_b[i] <= v;
  endtask
  task okc(input logic [3:0] e);
    chk("okOe_b", {12'h000, e}, {12'h000, okOe_b});
    chk("convOn", {12'h000, e}, {12'h000, convOn});
  endtask
  task tReset;
    okc(4'h0);
    chk("okOut", 16'h0000, {12'h000, okOut});
    rdc("status", `GIPC_REG_STATUS, 16'h0000);
    rdc("unmapped", 4'hF, 16'h0000);
    $display("test reset done");
  endtask
  task tOnOff;
    wr(`GIPC_REG_GROUP_CFG, 16'h000A);
    @(posedge clk);
    vinGood <= 1'b1;
    cyc(8);
    okc(4'hA);
    wr(`GIPC_REG_GROUP_CMD, 16'h0005);
    cyc(6);
    okc(4'hF);
    wr(`GIPC_REG_GROUP_CMD, 16'h0011);
    cyc(6);
    okc(4'hE);
    rdc("status", `GIPC_REG_STATUS, 16'h0E0E);
    wr(`GIPC_REG_GROUP_CMD, 16'h0001);
    cyc(6);
    okc(4'hF);
    rdc("groupOn", `GIPC_REG_GROUP_CMD, 16'h000F);
    rdc("groupCfg", `GIPC_REG_GROUP_CFG, 16'h000A);
    $display("test on-off done");
  endtask
  task tMargin;
    logic [3:0] up;
    logic [3:0] dn;
    for (int g = 0; g < 4; g++) begin
      for (int d = 0; d < 4; d++) begin
        up = (d == 1) ? 4'h1 << g : 4'h0;
        dn = (d == 2) ? 4'h1 << g : 4'h0;
        wr(`GIPC_REG_MARGIN_CMD, {12'h000, d[1:0], g[1:0]});
        rdc("margin", `GIPC_REG_MARGIN_CMD, {8'h00, dn, up});
        chk("marginUp", {12'h000, up}, {12'h000, marginUp});
        chk("marginDown", {12'h000, dn}, {12'h000, marginDown});
      end
    end
    $display("test margin done");
  endtask
  task tInhibit;
    wr(`GIPC_REG_INT_FUNC, 16'h0000);
    wr(`GIPC_REG_INT_MAP, 16'h0023);
    rdc("intMap", `GIPC_REG_INT_MAP, 16'h0023);
    rdc("intFunc", `GIPC_REG_INT_FUNC, 16'h0000);
    pin(0, 1'b0);
    cyc(3);
    pin(0, 1'b1);
    cyc(INH + 10);
    okc(4'hF);
    pin(0, 1'b0);
    cyc(INH + 10);
    okc(4'hC);
    rdc("status", `GIPC_REG_STATUS, 16'h0C1F);
    pin(1, 1'b0);
    cyc(INH + 10);
    pin(0, 1'b1);
    cyc(8);
    okc(4'hD);
    pin(1, 1'b1);
    cyc(8);
    okc(4'hF);
    $display("test inhibit done");
  endtask
  task tReprog;
    int n;
    wr(`GIPC_REG_GROUP_CFG, 16'h0001);
    wr(`GIPC_REG_GROUP_CMD, 16'h0010);
    wr(`GIPC_REG_INT_FUNC, 16'h0001);
    wr(`GIPC_REG_INT_MAP, 16'h0013);
    rdc("intFunc", `GIPC_REG_INT_FUNC, 16'h0001);
    cyc(4);
    okc(4'hE);
    pin(1, 1'b0);
    cyc(INH + 10);
    pin(0, 1'b0);
    n = 0;
    while (progReq[0] !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    chk("reqDelay", 16'(INH + 4), 16'(n));
    cyc(1);
    chk("progReq", 16'h0000, {12'h000, progReq});
    cyc(INH + 12);
    okc(4'hE);
    rdc("status", `GIPC_REG_STATUS, 16'h1E3F);
    pin(1, 1'b1);
    cyc(8);
    okc(4'hF);
    pin(0, 1'b1);
    cyc(8);
    okc(4'hE);
    rdc("status", `GIPC_REG_STATUS, 16'h0E0E);
    $display("test reprogram done");
  endtask
  initial begin
    nErrors = 0;
    totalChecks = 0;
    rst_b = 1'b0;
    addr = 4'h0;
    wrData = 16'h0000;
    wrStb = 1'b0;
    rdStb = 1'b0;
    intPin_b = 4'hF;
    vinGood = 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    cyc(2);
    tReset;
    tOnOff;
    tMargin;
    tInhibit;
    tReprog;
    completeRun;
  end
  initial begin
    #100000;
    $display("[ERR] watchdog expected end seen hang");
    nErrors++;
    completeRun;
  end
endmodule
